// ==== logic/profile_position_sequencer.sv ====
// profile position command sequencer with apb register file
//
// What this block does
// - mode value one selects profile position
// - rising start bit launches a travel command
// - entering mode with start high still starts
// - immediate bit runs now, else queued behind a running move
// - relative bit chooses absolute or relative target
// - option bits pick relative reference position
// - halt bit stops using halt option ramp
// - blend bit passes through current target
// - no blend: finish positioning then next
// - target reached after window dwell time
// - limit flag when demand outside limits
// - acknowledge follows host new setpoint bit
// - buffered ack clears when queue frees; ignore
// - no ack if unreachable or queue full
// - following error flag after window timeout
// - write target, start, ack, move, reached
// - option bits four/five auto clear start
// - one queued target with own parameters
// - blend holds speed until target reached
// - nonzero end speed: sampled position bases next relative move
// - profile type three enables jerk limits
// - speed capped by smaller maximum
// - evaluation runs once per millisecond tick; halt follows on every clock
`timescale 1ns/1ps
`default_nettype none
module profile_position_sequencer
	import pp_seq_pkg::*;
#(
	parameter int TICK_PERIOD = TICK_CYCLES
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// feedback from trajectory and position loop
	input  wire logic [31:0] actual_pos,
	input  wire logic [31:0] demand_pos,
	input  wire logic        traj_done,
	input  wire logic        closed_loop,
	// commands to trajectory generator
	output move_cmd_t        move_cmd,
	output logic             move_start,
	output logic             move_halt,
	output logic [15:0]      halt_mode,
	output logic             jerk_limited
);

	typedef struct packed {
		logic [15:0] ctrl;
		logic [7:0]  mode;
		logic [31:0] target;
		logic [15:0] option;
		logic [31:0] prof_vel;
		logic [31:0] end_vel;
		logic [31:0] max_prof_vel;
		logic [31:0] max_motor;
		logic [31:0] lim_min;
		logic [31:0] lim_max;
		logic [31:0] pos_win;
		logic [15:0] pos_win_time;
		logic [31:0] fe_win;
		logic [15:0] fe_time;
		logic [7:0]  prof_type;
		logic [15:0] halt_opt;
		seq_state_t  state;
		logic        start_prev;
		logic        was_pp;
		logic        done_pend;
		logic [31:0] act;
		logic [31:0] base;
		move_cmd_t   active;
		move_cmd_t   queued;
		logic        start;
		logic        ack;
		logic        reached;
		logic        limit;
		logic        follow;
		logic        jerk;
		logic        halt;
		logic [15:0] win_cnt;
		logic [15:0] fe_cnt;
		logic [15:0] tick_cnt;
		logic        tick;
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
	} regs_t;

	localparam regs_t REGS_RST = '{
		ctrl: CONTROL_RST, mode: MODE_RST, target: 32'h0000_0000, option: 16'h0000,
		prof_vel: SPEED_RST, end_vel: SPEED_RST, max_prof_vel: SPEED_RST,
		max_motor: SPEED_RST, lim_min: LIMIT_MIN_RST, lim_max: LIMIT_MAX_RST,
		pos_win: WIN_RST, pos_win_time: TIME_RST, fe_win: WIN_RST, fe_time: TIME_RST,
		prof_type: PROF_TRAPEZOID, halt_opt: 16'h0000, state: S_IDLE,
		start_prev: 1'b0, was_pp: 1'b0, done_pend: 1'b0, act: 32'h0000_0000,
		base: 32'h0000_0000, active: '0, queued: '0, start: 1'b0, ack: 1'b0,
		reached: 1'b0, limit: 1'b0, follow: 1'b0, jerk: 1'b0, win_cnt: 16'h0000,
		fe_cnt: 16'h0000, tick_cnt: 16'h0000, tick: 1'b0, rdata: 32'h0000_0000,
		ready: 1'b0, slverr: 1'b0, halt: 1'b0
	};

	localparam logic [15:0] TICK_LAST = 16'(TICK_PERIOD - 1);

	regs_t r_q;
	regs_t r_d;

	function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
		logic signed [32:0] d;
		d = $signed({a[31], a}) - $signed({b[31], b});
		abs_diff = d[32] ? 32'(-d) : d[31:0];
	endfunction

	function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
		umin = (a < b) ? a : b;
	endfunction

	logic        pp;
	logic        rise;
	logic        immed;
	logic        valid;
	logic        accepted;
	logic [31:0] ref_pos;
	logic [31:0] abs_tgt;
	move_cmd_t   cand;
	logic        access;
	logic        in_win;
	logic        fe_over;

	always_comb begin
		r_d      = r_q;
		pp       = (r_q.mode == MODE_PROFILE_POS);
		immed    = r_q.ctrl[CTL_IMMED];
		accepted = 1'b0;
		// window flags only matter at a tick; zero keeps the process latch free
		in_win   = 1'b0;
		fe_over  = 1'b0;
		r_d.start = 1'b0;
		// 1 ms application tick; inputs shorter than a tick may be missed
		r_d.tick = 1'b0;
		if (r_q.tick_cnt == TICK_LAST) begin
			r_d.tick_cnt = 16'h0000;
			r_d.tick     = 1'b1;
		end else begin
			r_d.tick_cnt = r_q.tick_cnt + 16'h0001;
		end
		// a late done is held until the next tick, never dropped
		if (traj_done) begin
			r_d.done_pend = 1'b1;
		end
		// entering the mode forgets the old start level
		rise = r_q.ctrl[CTL_START] & ~(r_q.was_pp & r_q.start_prev);
		case (r_q.option[OPT_REF_LSB +: 2])
			REF_LAST:   ref_pos = r_q.base;
			REF_DEMAND: ref_pos = demand_pos;
			default:    ref_pos = r_q.act;
		endcase
		// relative moves add the distance to the chosen reference
		abs_tgt = r_q.ctrl[CTL_REL] ? ref_pos + r_q.target : r_q.target;
		cand.target  = abs_tgt;
		// speed ceiling is the smaller of the two maxima
		cand.speed   = umin(r_q.prof_vel, umin(r_q.max_prof_vel, r_q.max_motor));
		cand.end_vel = r_q.end_vel;
		cand.blend   = r_q.ctrl[CTL_BLEND] & ~immed;
		// out of range: no acknowledge and no launch
		valid = ($signed(abs_tgt) >= $signed(r_q.lim_min))
			&& ($signed(abs_tgt) <= $signed(r_q.lim_max));
		if (r_q.tick) begin
			r_d.act  = actual_pos;
			r_d.jerk = (r_q.prof_type == PROF_JERK);
			r_d.limit = ($signed(demand_pos) < $signed(r_q.lim_min))
				|| ($signed(demand_pos) > $signed(r_q.lim_max));
			if (!pp) begin
				r_d.was_pp = 1'b0;
				r_d.state  = S_IDLE;
				r_d.ack    = 1'b0;
			end else begin
				r_d.was_pp     = 1'b1;
				r_d.start_prev = r_q.ctrl[CTL_START];
				if (r_q.done_pend && !traj_done) begin
					r_d.done_pend = 1'b0;
				end
				if (r_q.done_pend) begin
					// with nonzero end speed the sample replaces the ideal target
					r_d.base = (r_q.active.end_vel != 32'h0000_0000) ? actual_pos
						: r_q.active.target;
					case (r_q.state)
						S_QUEUE: begin
							r_d.active = r_q.queued;
							r_d.start  = 1'b1;
							r_d.state  = S_MOVE;
						end
						S_MOVE: begin
							r_d.state = S_IDLE;
						end
						default: begin
							r_d.state = S_IDLE;
						end
					endcase
				end
				// ack follows the start bit, but stays up while the queue is full
				if (!r_q.ctrl[CTL_START] && r_d.state != S_QUEUE) begin
					r_d.ack = 1'b0;
				end
				if (rise && valid) begin
					if (immed) begin
						r_d.active = cand;
						r_d.start  = 1'b1;
						r_d.state  = S_MOVE;
						accepted   = 1'b1;
					end else if (r_d.state == S_IDLE) begin
						r_d.active = cand;
						r_d.start  = 1'b1;
						r_d.state  = S_MOVE;
						accepted   = 1'b1;
					end else if (r_d.state == S_MOVE && !r_q.ack) begin
						r_d.queued = cand;
						r_d.state  = S_QUEUE;
						accepted   = 1'b1;
					end
					// queue full or ack still set: command ignored
				end
				if (accepted) begin
					r_d.ack = 1'b1;
					if (r_q.option[OPT_CLR_LSB +: 2] != 2'h0) begin
						r_d.ctrl[CTL_START] = 1'b0;
					end
				end
			end
			// dwell inside the window before reporting arrival
			in_win = (r_d.state == S_IDLE) && !r_d.start
				&& (abs_diff(actual_pos, r_d.active.target) <= r_q.pos_win);
			if (!in_win) begin
				r_d.win_cnt = 16'h0000;
				r_d.reached = 1'b0;
			end else if (r_q.win_cnt >= r_q.pos_win_time) begin
				r_d.reached = 1'b1;
			end else begin
				r_d.win_cnt = r_q.win_cnt + 16'h0001;
			end
			// open loop has no meaningful following error
			fe_over = closed_loop && (abs_diff(actual_pos, demand_pos) > r_q.fe_win);
			if (!fe_over) begin
				r_d.fe_cnt = 16'h0000;
				r_d.follow = 1'b0;
			end else if (r_q.fe_cnt >= r_q.fe_time) begin
				r_d.follow = 1'b1;
			end else begin
				r_d.fe_cnt = r_q.fe_cnt + 16'h0001;
			end
		end
		// apb: registered read data, one ready cycle per access
		r_d.ready = psel & ~penable;
		access    = psel & penable & r_q.ready;
		if (psel && !penable) begin
			r_d.slverr = 1'b0;
			r_d.rdata  = 32'h0000_0000;
			if (paddr == OFS_CONTROL) begin
				r_d.rdata = {16'h0000, r_q.ctrl};
			end else if (paddr == OFS_STATUS) begin
				r_d.rdata[ST_REACHED] = r_q.reached;
				r_d.rdata[ST_LIMIT]   = r_q.limit;
				r_d.rdata[ST_ACK]     = r_q.ack;
				r_d.rdata[ST_FOLLOW]  = r_q.follow;
			end else if (paddr == OFS_MODE) begin
				r_d.rdata = {24'h000000, r_q.mode};
			end else if (paddr == OFS_TARGET) begin
				r_d.rdata = r_q.target;
			end else if (paddr == OFS_OPTION) begin
				r_d.rdata = {16'h0000, r_q.option};
			end else if (paddr == OFS_PROF_VEL) begin
				r_d.rdata = r_q.prof_vel;
			end else if (paddr == OFS_END_VEL) begin
				r_d.rdata = r_q.end_vel;
			end else if (paddr == OFS_MAX_PROF_VEL) begin
				r_d.rdata = r_q.max_prof_vel;
			end else if (paddr == OFS_MAX_MOTOR) begin
				r_d.rdata = r_q.max_motor;
			end else if (paddr == OFS_LIMIT_MIN) begin
				r_d.rdata = r_q.lim_min;
			end else if (paddr == OFS_LIMIT_MAX) begin
				r_d.rdata = r_q.lim_max;
			end else if (paddr == OFS_POS_WIN) begin
				r_d.rdata = r_q.pos_win;
			end else if (paddr == OFS_POS_WIN_TIME) begin
				r_d.rdata = {16'h0000, r_q.pos_win_time};
			end else if (paddr == OFS_FE_WIN) begin
				r_d.rdata = r_q.fe_win;
			end else if (paddr == OFS_FE_TIME) begin
				r_d.rdata = {16'h0000, r_q.fe_time};
			end else if (paddr == OFS_PROF_TYPE) begin
				r_d.rdata = {24'h000000, r_q.prof_type};
			end else if (paddr == OFS_HALT_OPT) begin
				r_d.rdata = {16'h0000, r_q.halt_opt};
			end else if (paddr == OFS_ACTUAL) begin
				r_d.rdata = r_q.act;
			end else if (paddr == OFS_ACTIVE_TGT) begin
				r_d.rdata = r_q.active.target;
			end else begin
				r_d.slverr = 1'b1;
			end
		end
		// software write beats the auto clear of the start bit
		if (access && pwrite) begin
			if (paddr == OFS_CONTROL) begin
				r_d.ctrl = pwdata[15:0];
			end else if (paddr == OFS_MODE) begin
				r_d.mode = pwdata[7:0];
			end else if (paddr == OFS_TARGET) begin
				r_d.target = pwdata;
			end else if (paddr == OFS_OPTION) begin
				r_d.option = pwdata[15:0];
			end else if (paddr == OFS_PROF_VEL) begin
				r_d.prof_vel = pwdata;
			end else if (paddr == OFS_END_VEL) begin
				r_d.end_vel = pwdata;
			end else if (paddr == OFS_MAX_PROF_VEL) begin
				r_d.max_prof_vel = pwdata;
			end else if (paddr == OFS_MAX_MOTOR) begin
				r_d.max_motor = pwdata;
			end else if (paddr == OFS_LIMIT_MIN) begin
				r_d.lim_min = pwdata;
			end else if (paddr == OFS_LIMIT_MAX) begin
				r_d.lim_max = pwdata;
			end else if (paddr == OFS_POS_WIN) begin
				r_d.pos_win = pwdata;
			end else if (paddr == OFS_POS_WIN_TIME) begin
				r_d.pos_win_time = pwdata[15:0];
			end else if (paddr == OFS_FE_WIN) begin
				r_d.fe_win = pwdata;
			end else if (paddr == OFS_FE_TIME) begin
				r_d.fe_time = pwdata[15:0];
			end else if (paddr == OFS_PROF_TYPE) begin
				r_d.prof_type = pwdata[7:0];
			end else if (paddr == OFS_HALT_OPT) begin
				r_d.halt_opt = pwdata[15:0];
			end
		end

		// halt held in a flop so the pin has no gate behind it
		r_d.halt = r_d.ctrl[CTL_HALT] & (r_d.mode == MODE_PROFILE_POS);
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			r_q <= REGS_RST;
		end else begin
			r_q <= r_d;
		end
	end

	assign prdata       = r_q.rdata;
	assign pready       = r_q.ready;
	assign pslverr      = r_q.slverr;
	assign move_cmd     = r_q.active;
	assign move_start   = r_q.start;
	// halt is a level: rising brakes on the halt option ramp, falling restarts
	assign move_halt    = r_q.halt;
	assign halt_mode    = r_q.halt_opt;
	assign jerk_limited = r_q.jerk;

endmodule
`default_nettype wire

// ==== logic/pp_seq_pkg.sv ====
// constants, types and register map for the profile position sequencer
`default_nettype none
package pp_seq_pkg;
	// timing
	localparam int CLK_HZ      = 50_000_000;
	localparam int CYCLE_MS    = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * CYCLE_MS;

	// register byte offsets
	localparam logic [11:0] OFS_CONTROL      = 12'h000;
	localparam logic [11:0] OFS_STATUS       = 12'h004;
	localparam logic [11:0] OFS_MODE         = 12'h008;
	localparam logic [11:0] OFS_TARGET       = 12'h00C;
	localparam logic [11:0] OFS_OPTION       = 12'h010;
	localparam logic [11:0] OFS_PROF_VEL     = 12'h014;
	localparam logic [11:0] OFS_END_VEL      = 12'h018;
	localparam logic [11:0] OFS_MAX_PROF_VEL = 12'h01C;
	localparam logic [11:0] OFS_MAX_MOTOR    = 12'h020;
	localparam logic [11:0] OFS_LIMIT_MIN    = 12'h024;
	localparam logic [11:0] OFS_LIMIT_MAX    = 12'h028;
	localparam logic [11:0] OFS_POS_WIN      = 12'h02C;
	localparam logic [11:0] OFS_POS_WIN_TIME = 12'h030;
	localparam logic [11:0] OFS_FE_WIN       = 12'h034;
	localparam logic [11:0] OFS_FE_TIME      = 12'h038;
	localparam logic [11:0] OFS_PROF_TYPE    = 12'h03C;
	localparam logic [11:0] OFS_HALT_OPT     = 12'h040;
	localparam logic [11:0] OFS_ACTUAL       = 12'h044;
	localparam logic [11:0] OFS_ACTIVE_TGT   = 12'h048;

	// control word bits
	localparam int CTL_START = 4;
	localparam int CTL_IMMED = 5;
	localparam int CTL_REL   = 6;
	localparam int CTL_HALT  = 8;
	localparam int CTL_BLEND = 9;
	// status word bits
	localparam int ST_REACHED = 10;
	localparam int ST_LIMIT   = 11;
	localparam int ST_ACK     = 12;
	localparam int ST_FOLLOW  = 13;
	// positioning option fields
	localparam int OPT_REF_LSB = 0;
	localparam int OPT_CLR_LSB = 4;
	localparam logic [1:0] REF_LAST   = 2'h0;
	localparam logic [1:0] REF_DEMAND = 2'h1;

	localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
	localparam logic [7:0] PROF_TRAPEZOID   = 8'h00;
	localparam logic [7:0] PROF_JERK        = 8'h03;

	// reset values
	localparam logic [15:0] CONTROL_RST   = 16'h0000;
	localparam logic [7:0]  MODE_RST      = 8'h00;
	localparam logic [31:0] LIMIT_MIN_RST = 32'h8000_0000;
	localparam logic [31:0] LIMIT_MAX_RST = 32'h7FFF_FFFF;
	localparam logic [31:0] SPEED_RST     = 32'h0000_0000;
	localparam logic [31:0] WIN_RST       = 32'h0000_0000;
	localparam logic [15:0] TIME_RST      = 16'h0000;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_MOVE  = 3'b010,
		S_QUEUE = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic [31:0] target;
		logic [31:0] speed;
		logic [31:0] end_vel;
		logic        blend;
	} move_cmd_t;
endpackage
`default_nettype wire

// ==== verification/pp_seq_monitor.sv ====
// concurrent checks on the sequencer's bus and command ports
`timescale 1ns/1ps
`default_nettype none
module pp_seq_monitor
	import pp_seq_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        reset_n,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// trajectory side
	input wire logic [31:0] actual_pos,
	input wire logic [31:0] demand_pos,
	input wire logic        traj_done,
	input wire logic        closed_loop,
	input wire move_cmd_t   move_cmd,
	input wire logic        move_start,
	input wire logic        move_halt,
	input wire logic [15:0] halt_mode,
	input wire logic        jerk_limited
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && pready;
	endsequence
	sequence halt_wr_s;
		access_s ##0 (pwrite && paddr == OFS_HALT_OPT);
	endsequence
	a_ready_setup: assert property (setup_s |=> access_s)
		else $error("no answer after setup");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_ready_once: assert property (access_s |=> !pready)
		else $error("ready held too long");
	a_err_data: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
		else $error("data on error");
	a_start_spaced: assert property (move_start |=> !move_start [*8])
		else $error("launches too close");
	a_cmd_launch: assert property ($changed(move_cmd) |-> move_start)
		else $error("command changed without launch");
	a_jerk_tick: assert property ($changed(jerk_limited) |=> $stable(jerk_limited) [*8])
		else $error("jerk flag off tick");
	a_halt_copy: assert property (halt_wr_s |=> {16'h0000, halt_mode} == ($past(pwdata) & 32'h0000_FFFF))
		else $error("halt option not copied");
	c_launch: cover property (move_start);
endmodule
bind profile_position_sequencer pp_seq_monitor mon_u (.core_clk(core_clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .actual_pos(actual_pos),
	.demand_pos(demand_pos), .traj_done(traj_done), .closed_loop(closed_loop),
	.move_cmd(move_cmd), .move_start(move_start), .move_halt(move_halt),
	.halt_mode(halt_mode), .jerk_limited(jerk_limited));
`default_nettype wire

// ==== verification/traj_model.sv ====
// trajectory stand-in: reports arrival a fixed time after each launch
`timescale 1ns/1ps
`default_nettype none
module traj_model
	import pp_seq_pkg::*;
#(
	parameter int DONE_DLY = 300
) (
	// clock and reset
	input  wire logic      core_clk,
	input  wire logic      reset_n,
	// commands in
	input  wire move_cmd_t move_cmd,
	input  wire logic      move_start,
	// feedback out
	output logic [31:0]    actual_pos,
	output logic [31:0]    demand_pos,
	output logic           traj_done,
	output logic           closed_loop
);
	int cnt;
	// closed loop: demand jumps at launch, actual lands on arrival,
	// so a following error stands for the length of each run
	assign closed_loop = 1'b1;
	// a fresh launch restarts the run, as an immediate command would
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			actual_pos <= '0;
			demand_pos <= '0;
			traj_done <= 1'b0;
		end else begin
			traj_done <= (cnt == 1) && !move_start;
			cnt <= move_start ? DONE_DLY : (cnt > 0 ? cnt - 1 : 0);
			if (move_start) begin
				demand_pos <= move_cmd.target;
			end else if (cnt == 1) begin
				actual_pos <= move_cmd.target;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the profile position sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pp_seq_pkg::*;
;
	localparam int TP = 20;
	logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, er, ok;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, actual_pos, demand_pos, rdat, t1, t2, t4, ho;
	logic        traj_done, closed_loop, move_start, move_halt, jerk_limited;
	logic [15:0] halt_mode;
	move_cmd_t   move_cmd;
	int          err_count, num_checks, seed;

	profile_position_sequencer #(.TICK_PERIOD(TP)) dut_u (.core_clk(core_clk),
		.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .actual_pos(actual_pos), .demand_pos(demand_pos),
		.traj_done(traj_done), .closed_loop(closed_loop), .move_cmd(move_cmd),
		.move_start(move_start), .move_halt(move_halt), .halt_mode(halt_mode),
		.jerk_limited(jerk_limited));
	traj_model #(.DONE_DLY(300)) far_u (.core_clk(core_clk), .reset_n(reset_n),
		.move_cmd(move_cmd), .move_start(move_start), .actual_pos(actual_pos),
		.demand_pos(demand_pos), .traj_done(traj_done), .closed_loop(closed_loop));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic complete_run();
		if (err_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// request held until ready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check("pready", 1, 32'(pready));
		rdat = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ticks(input int n);
		repeat (n * TP) @(posedge core_clk);
	endtask
	task automatic wait_start(input int lim);
		ok = 1'b0;
		for (int i = 0; i < lim && !ok; i++) begin
			@(negedge core_clk);
			ok = (move_start === 1'b1);
		end
	endtask
	function automatic logic [31:0] min3(input logic [31:0] a, b, c);
		logic [31:0] m;
		m = (a < b) ? a : b;
		return (m < c) ? m : c;
	endfunction

	initial begin
		#(TP * 20 * 1000);
		err_count++;
		complete_run();
	end
	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		err_count = 0;
		num_checks = 0;
		seed = 32'h9d8a;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		apb(0, OFS_LIMIT_MIN, 0);
		check("limit_min", LIMIT_MIN_RST, rdat);
		apb(0, OFS_LIMIT_MAX, 0);
		check("limit_max", LIMIT_MAX_RST, rdat);
		apb(1, 12'h100, 32'hFFFF_FFFF);
		check("unmapped err", 1, 32'(er));
		apb(1, OFS_STATUS, 32'hFFFF_FFFF);
		apb(0, OFS_STATUS, 0);
		check("status ro", 0, rdat);
		apb(1, OFS_MODE, 32'(MODE_PROFILE_POS));
		t1 = $random(seed) & 32'h0000_FFFF;
		t2 = $random(seed) & 32'h0000_FFFF;
		ho = $random(seed) & 32'h0000_FFFF;
		apb(1, OFS_PROF_VEL, t1);
		apb(1, OFS_MAX_PROF_VEL, t2);
		apb(1, OFS_MAX_MOTOR, ho);
		apb(0, OFS_MAX_MOTOR, 0);
		check("max_motor", ho, rdat);
		apb(1, OFS_HALT_OPT, ho ^ 32'h0000_00A5);
		t4 = min3(t1, t2, ho);
		t1 = $random(seed) & 32'h00FF_FFFF;
		apb(1, OFS_TARGET, t1);
		apb(1, OFS_CONTROL, 32'h0000_0010);
		wait_start(3 * TP);
		check("launch", 1, 32'(ok));
		check("target", t1, move_cmd.target);
		check("speed", t4, move_cmd.speed);
		check("blend", 0, 32'(move_cmd.blend));
		apb(0, OFS_STATUS, 0);
		check("ack", 1, 32'(rdat[ST_ACK]));
		ticks(20);
		apb(0, OFS_STATUS, 0);
		check("reached", 1, 32'(rdat[ST_REACHED]));
		apb(1, OFS_CONTROL, 0);
		ticks(2);
		apb(0, OFS_STATUS, 0);
		check("ack low", 0, 32'(rdat[ST_ACK]));
		t2 = ($random(seed) & 32'h0000_FFFF) | 32'h0000_0001;
		apb(1, OFS_TARGET, t2);
		apb(1, OFS_CONTROL, 32'h0000_0250);
		wait_start(3 * TP);
		check("relative", t1 + t2, move_cmd.target);
		check("blend", 1, 32'(move_cmd.blend));
		apb(1, OFS_CONTROL, 32'h0000_0020);
		ticks(2);
		apb(0, OFS_STATUS, 0);
		check("follow", 1, 32'(rdat[ST_FOLLOW]));
		apb(1, OFS_TARGET, t1);
		apb(1, OFS_CONTROL, 32'h0000_0030);
		wait_start(3 * TP);
		check("immediate", t1, move_cmd.target);
		apb(1, OFS_CONTROL, 0);
		ticks(2);
		t4 = ($random(seed) & 32'h00FF_FFFF) | 32'h0000_1000;
		apb(1, OFS_TARGET, t4);
		apb(1, OFS_CONTROL, 32'h0000_0010);
		wait_start(2 * TP);
		check("queued wait", 0, 32'(ok));
		wait_start(20 * TP);
		check("queued target", t4, move_cmd.target);
		apb(1, OFS_CONTROL, 0);
		ticks(20);
		apb(1, OFS_LIMIT_MAX, 32'h0000_0100);
		apb(1, OFS_TARGET, 32'h0000_0200);
		apb(1, OFS_CONTROL, 32'h0000_0030);
		wait_start(3 * TP);
		check("refused", 0, 32'(ok));
		apb(0, OFS_STATUS, 0);
		check("no ack", 0, 32'(rdat[ST_ACK]));
		check("limit", 1, 32'(rdat[ST_LIMIT]));
		apb(1, OFS_PROF_TYPE, 32'(PROF_JERK));
		ticks(2);
		check("jerk", 1, 32'(jerk_limited));
		apb(1, OFS_PROF_TYPE, 32'(PROF_TRAPEZOID));
		ticks(2);
		check("no jerk", 0, 32'(jerk_limited));
		apb(1, OFS_CONTROL, 32'h0000_0100);
		@(negedge core_clk);
		check("halt", 1, 32'(move_halt));
		check("halt_mode", ho ^ 32'h0000_00A5, 32'(halt_mode));
		apb(1, OFS_MODE, 0);
		@(negedge core_clk);
		check("halt off mode", 0, 32'(move_halt));
		apb(1, OFS_LIMIT_MAX, LIMIT_MAX_RST);
		apb(1, OFS_OPTION, 32'h0000_0010);
		apb(1, OFS_TARGET, 32'h0000_0080);
		apb(1, OFS_CONTROL, 32'h0000_0010);
		ticks(2);
		apb(1, OFS_MODE, 32'(MODE_PROFILE_POS));
		wait_start(3 * TP);
		check("mode entry start", 1, 32'(ok));
		apb(0, OFS_CONTROL, 0);
		check("auto clear", 0, 32'(rdat[CTL_START]));
		complete_run();
	end
endmodule
`default_nettype wire
